// [verilog/long_timer_consts.svh]
// register offsets, field positions, reset values and timing counts
`ifndef LONG_TIMER_CONSTS_SVH
`define LONG_TIMER_CONSTS_SVH
`define OFS_COUNTER_VALUE   4'h0
`define OFS_COUNTER_CONTROL 4'h1
`define OFS_COUNT_MODE      4'h2
`define OFS_LINK_SELECT_7   4'h3
`define OFS_CLOCK_CTRL_1ST  4'h4
`define OFS_CLOCK_CTRL_2ND  4'h5
`define OFS_INT_MASK_HIGH   4'h6
`define OFS_INT_REQ_HIGH    4'h7
`define BIT_COUNT_START     0
`define BIT_UNDERFLOW       5
`define BIT_CLOCK_RUN       7
`define BIT_WAIT_CONTROL    0
`define BIT_WAIT_STATUS     1
`define BIT_COUNTER_INT     6
`define LINK_TO_COUNTER     4'h4
`define LINK_MAX_CODE       4'h9
`define SRC_LINKED_EVENT    3'h5
`define CYCLE_ONE_SECOND    3'h2
`define CYCLE_HALF_SECOND   3'h1
`define SOURCE_FIELD        6:4
`define LINK_FIELD          3:0
`define CYCLE_FIELD         2:0
`define CLOCK_CTRL_WMASK    8'hbf
`define DIVIDER_LIMIT       (2**28)
`define RST_COUNTER_VALUE   16'hffff
`define RST_INT_MASK        8'hff
`define CLOCK_HZ            250000000
`define SECOND_CYCLES       (`CLOCK_HZ)
`define HALF_SECOND_CYCLES  (`CLOCK_HZ / 2)
`endif

// [verilog/long_timer_pkg.sv]
// types shared by the long interval timer
package long_timer_pkg;
   typedef struct packed {
      logic        read;
      logic        write;
      logic [3:0]  address;
      logic [31:0] writedata;
   } bus_req_t;
   typedef struct packed {
      logic [31:0] readdata;
      logic        waitrequest;
   } bus_rsp_t;
   typedef enum logic [1:0] {
      bus_idle = 2'b00,
      bus_done = 2'b01
   } bus_state_t;
endpackage : long_timer_pkg

// [verilog/cycle_divider.sv]
// divider making one-cycle enable pulses at a programmable period
module cycle_divider #(
   parameter int WIDTH = 28
) (
   input  wire logic             mclk,
   input  wire logic             reset_n,
   input  wire logic             run,
   input  wire logic [WIDTH-1:0] period,
   output logic                  tick
);
   typedef struct packed {
      logic [WIDTH-1:0] count;
      logic             tick;
   } div_state_t;
   div_state_t state_ff;
   div_state_t nxt_state;
   initial begin
      if (WIDTH < 2) $error("divider too narrow");
   end
   always_comb begin
      nxt_state = state_ff;
      nxt_state.tick = 1'b0;
      if (!run) begin
         nxt_state.count = '0;
      end else if (state_ff.count >= period - WIDTH'(1)) begin
         nxt_state.count = '0;
         nxt_state.tick  = 1'b1;
      end else begin
         nxt_state.count = state_ff.count + WIDTH'(1);
      end
   end
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff <= '0;
      end else begin
         state_ff <= nxt_state;
      end
   end
   assign tick = state_ff.tick;
endmodule : cycle_divider

// [verilog/long_timer.sv]
// event linked long interval timer with clock event source and bus slave
`include "long_timer_consts.svh"

// Behaviour
// - 16-bit count register sets start value; decrements per count event
// - link input 7 takes the clock's fixed-cycle event
// - link code 4 routes to counter; 0 off; 1..9 others; rest ignored
// - each linked event counts the counter down by one; at zero it reloads the start value instead
// - underflow flag in control bit 5; software clears it
// - control bit 0 starts counting at 1, stops at 0
// - first clock control bit 7 runs the clock counters
// - mask bit 6 zero allows the counter interrupt, one blocks it
// - request flag bit 6 reads 1 while a request is pending
// - wait control bit 0 halts the seconds counters for access
// - read-only wait status bit 1 reports halted counters
// - count source code 101 selects the linked event input
// - fixed-cycle code 010 gives one event per second
module long_timer
   import long_timer_pkg::*;
#(
   parameter int SECOND_CYCLES = `SECOND_CYCLES,
   parameter int HALF_CYCLES   = `HALF_SECOND_CYCLES
) (
   input  wire logic        mclk,
   input  wire logic        reset_n,
   input  wire logic [3:0]  avs_address,
   input  wire logic        avs_read,
   input  wire logic        avs_write,
   input  wire logic [31:0] avs_writedata,
   output logic [31:0]      avs_readdata,
   output logic             avs_waitrequest,
   output logic             counter_irq,
   output logic             second_tick
);
   typedef struct packed {
      bus_state_t  bus;
      logic [31:0] readdata;
      logic [15:0] reload;
      logic [15:0] count;
      logic        start;
      logic        underflow;
      logic [2:0]  source;
      logic [3:0]  link;
      logic [7:0]  clock_ctrl;
      logic        wait_ctrl;
      logic        wait_status;
      logic [7:0]  mask;
      logic [7:0]  request;
      logic        irq;
      logic        tick;
      logic        busy;
   } timer_state_t;

   timer_state_t state_ff;
   timer_state_t nxt_state;
   bus_req_t     req;
   logic         sec_pulse;
   logic         half_pulse;
   logic         clock_event;
   logic         count_event;
   logic         wr_take;
   logic         rd_take;

   initial begin
      if (SECOND_CYCLES < 2 || HALF_CYCLES < 1
          || SECOND_CYCLES >= `DIVIDER_LIMIT
          || HALF_CYCLES >= `DIVIDER_LIMIT) $error("bad period");
   end

   assign req = '{read: avs_read, write: avs_write,
                  address: avs_address, writedata: avs_writedata};

   // seconds divider halts while the clock is stopped or waiting
   cycle_divider #(.WIDTH(28)) u_second (
      .mclk    (mclk),
      .reset_n (reset_n),
      .run     (state_ff.clock_ctrl[`BIT_CLOCK_RUN] && !state_ff.wait_ctrl),
      .period  (28'(SECOND_CYCLES)),
      .tick    (sec_pulse)
   );

   cycle_divider #(.WIDTH(28)) u_half (
      .mclk    (mclk),
      .reset_n (reset_n),
      .run     (state_ff.clock_ctrl[`BIT_CLOCK_RUN] && !state_ff.wait_ctrl),
      .period  (28'(HALF_CYCLES)),
      .tick    (half_pulse)
   );

   always_comb begin
      unique case (state_ff.clock_ctrl[`CYCLE_FIELD])
         `CYCLE_ONE_SECOND:  clock_event = sec_pulse;
         `CYCLE_HALF_SECOND: clock_event = half_pulse;
         default:            clock_event = 1'b0;
      endcase
   end

   // link input 7 fed by the clock event, routed only by code 4
   assign count_event = clock_event
                      && state_ff.link == `LINK_TO_COUNTER
                      && state_ff.source == `SRC_LINKED_EVENT;

   // a write lands at the edge where the master sees waitrequest low
   assign wr_take = req.write && state_ff.bus == bus_done;
   assign rd_take = req.read && !req.write && state_ff.bus == bus_idle;

   always_comb begin
      logic [7:0] wb;
      wb = req.writedata[7:0];
      nxt_state = state_ff;
      nxt_state.tick = sec_pulse;
      // single wait cycle, answer on the second edge
      if (state_ff.bus == bus_done) begin
         nxt_state.bus = bus_idle;
      end else if (req.read || req.write) begin
         nxt_state.bus = bus_done;
      end
      nxt_state.busy = nxt_state.bus != bus_done;
      if (rd_take) begin
         nxt_state.readdata = '0;
         unique case (req.address)
            `OFS_COUNTER_VALUE:
               nxt_state.readdata[15:0] = state_ff.count;
            `OFS_COUNTER_CONTROL: begin
               nxt_state.readdata[`BIT_UNDERFLOW]   = state_ff.underflow;
               nxt_state.readdata[`BIT_COUNT_START] = state_ff.start;
            end
            `OFS_COUNT_MODE:
               nxt_state.readdata[`SOURCE_FIELD] = state_ff.source;
            `OFS_LINK_SELECT_7:
               nxt_state.readdata[`LINK_FIELD] = state_ff.link;
            `OFS_CLOCK_CTRL_1ST:
               nxt_state.readdata[7:0] = state_ff.clock_ctrl;
            `OFS_CLOCK_CTRL_2ND: begin
               nxt_state.readdata[`BIT_WAIT_STATUS]  = state_ff.wait_status;
               nxt_state.readdata[`BIT_WAIT_CONTROL] = state_ff.wait_ctrl;
            end
            `OFS_INT_MASK_HIGH:
               nxt_state.readdata[7:0] = state_ff.mask;
            `OFS_INT_REQ_HIGH:
               nxt_state.readdata[7:0] = state_ff.request;
            default:
               nxt_state.readdata = '0;
         endcase
      end
      // wait status follows the wait control one cycle later
      nxt_state.wait_status = state_ff.wait_ctrl;
      // counting: one step per linked event
      if (state_ff.start && count_event) begin
         if (state_ff.count == 16'h0000) begin
            nxt_state.count     = state_ff.reload;
            nxt_state.underflow = 1'b1;
            nxt_state.request[`BIT_COUNTER_INT] = 1'b1;
         end else begin
            nxt_state.count = state_ff.count - 16'h0001;
         end
      end
      if (wr_take) begin
         unique case (req.address)
            `OFS_COUNTER_VALUE: begin
               nxt_state.reload = req.writedata[15:0];
               nxt_state.count  = req.writedata[15:0];
            end
            `OFS_COUNTER_CONTROL: begin
               nxt_state.start = wb[`BIT_COUNT_START];
               // writing 0 clears, but a same-cycle underflow wins
               if (!wb[`BIT_UNDERFLOW] && !nxt_state.underflow) begin
                  nxt_state.underflow = 1'b0;
               end else if (!wb[`BIT_UNDERFLOW] && !state_ff.underflow) begin
                  nxt_state.underflow = 1'b1;
               end else if (!wb[`BIT_UNDERFLOW]
                            && !(state_ff.start && count_event
                                 && state_ff.count == 16'h0000)) begin
                  nxt_state.underflow = 1'b0;
               end
            end
            `OFS_COUNT_MODE:
               nxt_state.source = wb[`SOURCE_FIELD];
            `OFS_LINK_SELECT_7:
               if (wb[`LINK_FIELD] <= `LINK_MAX_CODE) begin
                  nxt_state.link = wb[`LINK_FIELD];
               end
            `OFS_CLOCK_CTRL_1ST:
               nxt_state.clock_ctrl = wb & `CLOCK_CTRL_WMASK;
            `OFS_CLOCK_CTRL_2ND:
               nxt_state.wait_ctrl = wb[`BIT_WAIT_CONTROL];
            `OFS_INT_MASK_HIGH:
               nxt_state.mask = wb;
            `OFS_INT_REQ_HIGH: begin
               // zeros clear set request bits even if an event sets them now; a clear bit still takes a new event
               nxt_state.request = (state_ff.request & wb)
                  | (nxt_state.request & ~state_ff.request);
            end
            default: ;
         endcase
      end
      nxt_state.irq = |(nxt_state.request & ~nxt_state.mask
                        & 8'(1 << `BIT_COUNTER_INT));
   end

   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) begin
         state_ff         <= '0;
         state_ff.reload  <= `RST_COUNTER_VALUE;
         state_ff.count   <= `RST_COUNTER_VALUE;
         state_ff.mask    <= `RST_INT_MASK;
         state_ff.busy    <= 1'b1;
      end else begin
         state_ff <= nxt_state;
      end
   end

   assign avs_readdata    = state_ff.readdata;
   assign avs_waitrequest = state_ff.busy;
   assign counter_irq     = state_ff.irq;
   assign second_tick     = state_ff.tick;
endmodule : long_timer

// [test/cpu_model.sv]
// bus master model standing in for the cpu software
module cpu_model (
   input  wire logic        mclk,
   output logic [3:0]       avs_address,
   output logic             avs_read,
   output logic             avs_write,
   output logic [31:0]      avs_writedata,
   input  wire logic        avs_waitrequest,
   output logic             timed_out
);
   timeunit 1ns;
   timeprecision 1ps;
   initial begin
      avs_address = 4'h0;
      avs_read = 1'b0;
      avs_write = 1'b0;
      avs_writedata = 32'h0;
      timed_out = 1'b0;
   end
   // holds the request until waitrequest is sampled low
   task automatic xfer(input logic we, input logic [3:0] a,
                       input logic [31:0] d);
      int n;
      @(posedge mclk);
      avs_address <= a;
      avs_write <= we;
      avs_read <= !we;
      avs_writedata <= d;
      n = 0;
      do begin
         @(posedge mclk);
         n++;
      end while (avs_waitrequest !== 1'b0 && n < 50);
      if (avs_waitrequest !== 1'b0) timed_out = 1'b1;
      avs_read <= 1'b0;
      avs_write <= 1'b0;
      avs_address <= ~a;
      avs_writedata <= ~d;
   endtask : xfer
endmodule : cpu_model

// [test/long_timer_monitor.sv]
// assertion checker on the long interval timer ports
module long_timer_monitor #(
   parameter int SECOND_CYCLES = 10,
   parameter int HALF_CYCLES   = 5
) (
   input wire logic        mclk,
   input wire logic        reset_n,
   input wire logic [3:0]  avs_address,
   input wire logic        avs_read,
   input wire logic        avs_write,
   input wire logic [31:0] avs_writedata,
   input wire logic [31:0] avs_readdata,
   input wire logic        avs_waitrequest,
   input wire logic        counter_irq,
   input wire logic        second_tick
);
   logic [31:0] gap_ff;
   logic [31:0] nxt_gap;
   assign nxt_gap = second_tick ? 32'h0 : gap_ff + 32'h1;
   always_ff @(posedge mclk or negedge reset_n) begin
      if (!reset_n) gap_ff <= 32'h0;
      else gap_ff <= nxt_gap;
   end
   default clocking cb @(posedge mclk);
   endclocking
   default disable iff (!reset_n);
   sequence s_taken;
      (avs_read || avs_write) && avs_waitrequest;
   endsequence
   sequence s_answer;
      !avs_waitrequest;
   endsequence
   a_answer_next: assert property (s_taken |=> s_answer)
      else $error("no answer one cycle after request");
   a_answer_single: assert property (s_answer |=> avs_waitrequest)
      else $error("answer longer than one cycle");
   a_unmapped_zero: assert property (avs_read && !avs_waitrequest
      && avs_address[3] |-> avs_readdata == 32'h0)
      else $error("unmapped read not zero");
   a_upper_zero: assert property (avs_read && !avs_waitrequest
      |-> avs_readdata[31:16] == 16'h0)
      else $error("read data upper half not zero");
   a_irq_holds: assert property (counter_irq && !avs_write
      |=> counter_irq)
      else $error("interrupt dropped without a write");
   a_mask_blocks: assert property (avs_write && !avs_waitrequest
      && avs_address == 4'h6 && avs_writedata[6] |=> !counter_irq)
      else $error("masked interrupt still high");
   a_clear_drops: assert property (avs_write && !avs_waitrequest
      && avs_address == 4'h7 && !avs_writedata[6] |=> !counter_irq)
      else $error("cleared interrupt still high");
   a_tick_single: assert property (second_tick |=> !second_tick)
      else $error("tick longer than one cycle");
   a_tick_gap: assert property (second_tick
      |-> gap_ff >= SECOND_CYCLES - 1)
      else $error("ticks too close together");
endmodule : long_timer_monitor
bind long_timer long_timer_monitor #(
   .SECOND_CYCLES(SECOND_CYCLES), .HALF_CYCLES(HALF_CYCLES)
) mon (
   .mclk, .reset_n, .avs_address, .avs_read, .avs_write,
   .avs_writedata, .avs_readdata, .avs_waitrequest,
   .counter_irq, .second_tick
);

// [test/testbench.sv]
// self-checking bench for the long interval timer
module testbench;
   timeunit 1ns;
   timeprecision 1ps;
   logic        mclk = 1'b0;
   logic        reset_n = 1'b0;
   logic [3:0]  avs_address;
   logic        avs_read;
   logic        avs_write;
   logic [31:0] avs_writedata;
   logic [31:0] avs_readdata;
   logic        avs_waitrequest;
   logic        counter_irq;
   logic        second_tick;
   logic        timed_out;
   int          fail_count = 0;
   int          compares = 0;
   int          seed = 47326;
   int          ticks = 0;
   int          t0 = 0;
   logic [31:0] exp_q[$];
   logic [15:0] v;
   always #2 mclk = ~mclk;
   long_timer #(.SECOND_CYCLES(10), .HALF_CYCLES(5)) uut (
      .mclk, .reset_n, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_readdata, .avs_waitrequest,
      .counter_irq, .second_tick);
   cpu_model cpu (.mclk, .avs_address, .avs_read, .avs_write,
      .avs_writedata, .avs_waitrequest, .timed_out);
   task automatic final_report();
      $display("compares %0d fail_count %0d", compares, fail_count);
      if (fail_count == 0 && compares > 0) $display("bench passed");
      else $display("bench failed");
      $finish;
   endtask : final_report
   task automatic check(input logic [31:0] got, input logic [31:0] exp);
      compares++;
      if (got !== exp) begin
         fail_count++;
         $display("Error at %0t: got %h expected %h", $time, got, exp);
      end
   endtask : check
   task automatic wait_on(ref logic s, input logic lvl);
      int n;
      n = 0;
      while (s !== lvl && n < 200) begin
         @(posedge mclk);
         n++;
      end
      check({31'h0, n < 200}, 32'h1);
      if (n >= 200) final_report();
   endtask : wait_on
   task automatic wr(input logic [3:0] a, input logic [31:0] d);
      cpu.xfer(1'b1, a, d);
   endtask : wr
   task automatic rd(input logic [3:0] a, input logic [31:0] e);
      exp_q.push_back(e);
      cpu.xfer(1'b0, a, 32'h0);
   endtask : rd
   // read results are compared in order of issue
   always @(posedge mclk) begin
      if (second_tick === 1'b1) ticks++;
      if (avs_read === 1'b1 && avs_waitrequest === 1'b0)
         check(avs_readdata, exp_q.pop_front());
   end
   always @(posedge timed_out) begin
      fail_count++;
      final_report();
   end
   initial begin
      repeat (20) @(posedge mclk);
      reset_n <= 1'b1;
      rd(4'h0, 32'hffff);
      rd(4'h6, 32'hff);
      rd(4'h7, 32'h0);
      rd(4'h1, 32'h0);
      for (int a = 8; a < 16; a++) begin
         wr(4'(a), 32'hff);
         rd(4'(a), 32'h0);
      end
      repeat (3) begin
         v = 16'($random(seed));
         wr(4'h0, {16'hffff, v});
         rd(4'h0, {16'h0, v});
      end
      for (int c = 0; c < 16; c++) begin
         wr(4'h3, 32'(c));
         rd(4'h3, c > 9 ? 32'h9 : 32'(c));
      end
      wr(4'h2, 32'h50);
      rd(4'h2, 32'h50);
      wr(4'h3, 32'h4);
      wr(4'h0, 32'h5);
      wr(4'h1, 32'h0);
      wr(4'h7, 32'h0);
      wr(4'h6, 32'hbf);
      wr(4'h4, 32'h82);
      wr(4'h1, 32'h1);
      wait_on(second_tick, 1'b1);
      rd(4'h0, 32'h4);
      wait_on(counter_irq, 1'b1);
      rd(4'h0, 32'h5);
      rd(4'h1, 32'h21);
      rd(4'h7, 32'h40);
      wr(4'h6, 32'hff);
      wait_on(counter_irq, 1'b0);
      wr(4'h6, 32'hbf);
      wait_on(counter_irq, 1'b1);
      wr(4'h7, 32'h0);
      wait_on(counter_irq, 1'b0);
      wr(4'h1, 32'h1);
      rd(4'h1, 32'h1);
      wr(4'h1, 32'h0);
      wr(4'h0, 32'h3);
      repeat (25) @(posedge mclk);
      rd(4'h0, 32'h3);
      wr(4'h3, 32'h0);
      wr(4'h1, 32'h1);
      repeat (25) @(posedge mclk);
      rd(4'h0, 32'h3);
      wr(4'h5, 32'h1);
      rd(4'h5, 32'h3);
      t0 = ticks;
      repeat (30) @(posedge mclk);
      check(32'(ticks - t0), 32'h0);
      wr(4'h5, 32'h0);
      rd(4'h5, 32'h0);
      wr(4'h4, 32'h2);
      t0 = ticks;
      repeat (30) @(posedge mclk);
      check(32'(ticks - t0), 32'h0);
      // half-second events with another source, then linked source
      wr(4'h3, 32'h4);
      wr(4'h2, 32'h40);
      wr(4'h4, 32'h81);
      repeat (25) @(posedge mclk);
      rd(4'h0, 32'h3);
      wr(4'h2, 32'h50);
      wait_on(counter_irq, 1'b1);
      rd(4'h0, 32'h3);
      rd(4'h1, 32'h21);
      final_report();
   end
endmodule : testbench
